// ===== dv/tb_cgs_status_ctrl.sv
// Self-checking testbench of the clock generator status block.
`timescale 1ns/1ps
`include "cgs_regs.svh"
module tb_cgs_status_ctrl;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic sysClk, arstN, regWr, regRd, loopSelect, referenceSelect, settingChange, stopEntry;
	logic lowPowerBypass, loopEnabled, loopInTolerance;
	logic finePeriodAdjust, oscillatorRequest, externalReferenceEnable, oscCrystalSelect, irq;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, d, prev;
	logic [1:0] clockSourceSelect;
	int mismatches = 0;
	int testsRun = 0;
	int cycles = 0;
	// A lock count of 8, below the default of 20, still keeps the dropped lock bit visible to a register read.
	cgs_status_ctrl #(.OSC_INIT_CYC(3), .LOCK_CYC(8)) cgs_status_ctrl_i (
		.sys_clk(sysClk), .arst_n(arstN), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .loopSelect(loopSelect),
		.referenceSelect(referenceSelect), .clockSourceSelect(clockSourceSelect),
		.settingChange(settingChange), .stopEntry(stopEntry), .lowPowerBypass(lowPowerBypass),
		.loopEnabled(loopEnabled), .loopInTolerance(loopInTolerance),
		.finePeriodAdjust(finePeriodAdjust), .oscillatorRequest(oscillatorRequest),
		.externalReferenceEnable(externalReferenceEnable),
		.oscCrystalSelect(oscCrystalSelect), .irq(irq));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic waitc(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sysClk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge sysClk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sysClk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sysClk);
		regRd <= 1'b0;
		#1;
		v = regRdata;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		testsRun++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic lockIs(input logic e);
		rd(`CGS_ADDR_STATUS, d);
		chk1(d[`CGS_BIT_LOCK], e);
	endtask
	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, reset and timeout
	// ----------------------------------------
	initial begin
		sysClk = 1'b0;
		forever #12.5 sysClk = ~sysClk;
	end
	// The tests need a few hundred cycles, so this ceiling only trips on a hang.
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			closeOut();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		arstN = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 8'h00;
		loopSelect = 1'b0; referenceSelect = 1'b1; clockSourceSelect = 2'h0;
		settingChange = 1'b0; stopEntry = 1'b0; lowPowerBypass = 1'b0;
		loopEnabled = 1'b0; loopInTolerance = 1'b1;
		repeat (20) @(posedge sysClk);
		arstN <= 1'b1;
		waitc(4);
		rd(`CGS_ADDR_STATUS, d); chk8(d, 8'h10);
		rd(`CGS_ADDR_CTRL, d); chk8(d, 8'h00);
		rd(4'hf, d); chk8(d, 8'h00);
		$display("test reset done");
		for (int i = 3; i >= 0; i--) begin
			rd(`CGS_ADDR_STATUS, prev);
			@(posedge sysClk);
			clockSourceSelect <= 2'(i);
			loopSelect <= i[0];
			referenceSelect <= ~i[1];
			rd(`CGS_ADDR_STATUS, d); chk8(d, prev);
			waitc(4);
			rd(`CGS_ADDR_STATUS, d);
			chk1(d[`CGS_BIT_LOOP], i[0]);
			chk1(d[`CGS_BIT_REF], ~i[1]);
			chk8({6'h00, d[`CGS_BIT_MODE_HI:`CGS_BIT_MODE_LO]}, 8'(i));
		end
		$display("test status select done");
		rd(`CGS_ADDR_STATUS, prev);
		wr(`CGS_ADDR_STATUS, 8'hff);
		waitc(1); chk1(finePeriodAdjust, 1'b1);
		rd(`CGS_ADDR_STATUS, d); chk8(d, {prev[7:1], 1'b1});
		wr(`CGS_ADDR_STATUS, 8'h00);
		waitc(1); chk1(finePeriodAdjust, 1'b0);
		$display("test trim done");
		waitc(20); lockIs(1'b0);
		@(posedge sysClk) loopEnabled <= 1'b1;
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) settingChange <= ~settingChange;
		waitc(4); lockIs(1'b0);
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) referenceSelect <= ~referenceSelect;
		waitc(4); lockIs(1'b0);
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) stopEntry <= 1'b1;
		waitc(4); lockIs(1'b0);
		@(posedge sysClk) stopEntry <= 1'b0;
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) lowPowerBypass <= 1'b1;
		waitc(20); lockIs(1'b0);
		@(posedge sysClk) lowPowerBypass <= 1'b0;
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) loopEnabled <= 1'b0;
		waitc(6); lockIs(1'b0);
		$display("test lock done");
		@(posedge sysClk) loopEnabled <= 1'b1;
		waitc(20); lockIs(1'b1);
		@(posedge sysClk) loopInTolerance <= 1'b0;
		waitc(10);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_LOSS], 1'b1);
		chk1(irq, 1'b0);
		rd(`CGS_ADDR_IRQ_STAT, d); chk8(d, 8'h80);
		wr(`CGS_ADDR_CTRL, 8'h01); waitc(2); chk1(irq, 1'b1);
		wr(`CGS_ADDR_STATUS, 8'h00);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_LOSS], 1'b1);
		wr(`CGS_ADDR_STATUS, 8'h80);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_LOSS], 1'b0);
		waitc(2); chk1(irq, 1'b0);
		wr(`CGS_ADDR_IRQ_MASK, 8'h80); waitc(2); chk1(irq, 1'b1);
		wr(`CGS_ADDR_IRQ_STAT, 8'h80); waitc(2); chk1(irq, 1'b0);
		$display("test loss and irq done");
		wr(`CGS_ADDR_CTRL, 8'h06);
		waitc(1); chk1(oscillatorRequest, 1'b1);
		chk1(externalReferenceEnable, 1'b1);
		chk1(oscCrystalSelect, 1'b1);
		rd(`CGS_ADDR_CTRL, d); chk8(d, 8'h06);
		waitc(8);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_OSC], 1'b1);
		wr(`CGS_ADDR_CTRL, 8'h04);
		waitc(1); chk1(oscCrystalSelect, 1'b0);
		waitc(2);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_OSC], 1'b0);
		// referenceSelect low keeps the oscillator in use without the enable, while the mode stays at CGS_MODE_FLL.
		wr(`CGS_ADDR_CTRL, 8'h02); waitc(8);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_OSC], 1'b1);
		@(posedge sysClk) referenceSelect <= 1'b1;
		waitc(4);
		rd(`CGS_ADDR_STATUS, d); chk1(d[`CGS_BIT_OSC], 1'b0);
		$display("test oscillator done");
		closeOut();
	end
endmodule

// ===== logic/cgs_pkg.sv
// Types shared by the clock generator status block.
package cgs_pkg;
	typedef enum logic [1:0] {
		CGS_MODE_FLL = 2'b00,
		CGS_MODE_IREF = 2'b01,
		CGS_MODE_EREF = 2'b10,
		CGS_MODE_PLL = 2'b11
	} cgs_mode_e;
	typedef enum logic [1:0] {
		CGS_LK_OFF = 2'b00,
		CGS_LK_ACQ = 2'b01,
		CGS_LK_LOCKED = 2'b10
	} cgs_lock_e;
endpackage

// ===== logic/cgs_regs.svh
// Register offsets, field positions, reset values and timings in ns of the status block.
`ifndef CGS_REGS_SVH
`define CGS_REGS_SVH
`define CGS_ADDR_STATUS 4'h0
`define CGS_ADDR_CTRL 4'h1
`define CGS_ADDR_IRQ_STAT 4'h2
`define CGS_ADDR_IRQ_MASK 4'h3
`define CGS_BIT_LOSS 7
`define CGS_BIT_LOCK 6
`define CGS_BIT_LOOP 5
`define CGS_BIT_REF 4
`define CGS_BIT_MODE_HI 3
`define CGS_BIT_MODE_LO 2
`define CGS_BIT_OSC 1
`define CGS_BIT_TRIM 0
`define CGS_CTRL_IRQ_EN 0
`define CGS_CTRL_OSC_REQ 1
`define CGS_CTRL_EXT_EN 2
`define CGS_RST_BYTE 8'h00
`define CGS_RST_MODE 2'h0
`define CGS_RST_REF 1'h1
`define CGS_RST_SYNC 8'h10
`define CGS_IRQ_MASK_BITS 8'h80
`define CGS_OSC_INIT_NS 1000
`define CGS_CLK_NS 25
`define CGS_LOCK_NS 500
`endif

// ===== logic/cgs_status_ctrl.sv
// Status and fine trim register of the multi purpose clock generator.
// Function
// - Sticky loss flag sets on drift after lock
// - Loss flag cleared by reset or write one
// - Interrupt only when loss interrupt enabled
// - Lock bit shows current lock state
// - No lock detection when both loops off
// - Setting changes drop lock until relock
// - Stop entry drops lock until relock
// - Low power bypass drops lock until exit
// - Loop status follows select after synchronisation
// - Reference status follows select after synchronisation
// - Mode status follows select after synchronisation
// - Oscillator ready set after init cycles
// - Oscillator ready cleared on release or when the oscillator is not in use
// - Fine trim bit lengthens or shortens period
// - Oscillator request picks crystal, else clock
// - Interrupt enable matters only while flag set
`timescale 1ns/1ps
`include "cgs_regs.svh"
module cgs_status_ctrl
	import cgs_pkg::*;
#(
	parameter int OSC_INIT_CYC = (`CGS_OSC_INIT_NS + `CGS_CLK_NS - 1) / `CGS_CLK_NS,
	parameter int LOCK_CYC = (`CGS_LOCK_NS + `CGS_CLK_NS - 1) / `CGS_CLK_NS
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Clock generator selects and events from the core.
	input wire logic loopSelect,
	input wire logic referenceSelect,
	input wire logic [1:0] clockSourceSelect,
	input wire logic settingChange,
	input wire logic stopEntry,
	input wire logic lowPowerBypass,
	input wire logic loopEnabled,
	input wire logic loopInTolerance,
	// Outputs to the oscillator and trim logic, and the interrupt.
	output logic finePeriodAdjust,
	output logic oscillatorRequest,
	output logic externalReferenceEnable,
	output logic oscCrystalSelect,
	output logic irq
);
	// The counters are 16 bits wide, so longer settling counts cannot be served.
	if (OSC_INIT_CYC < 1 || OSC_INIT_CYC > 65535 || LOCK_CYC < 1 || LOCK_CYC > 65535) begin : gBadCounts
		$error("cgs_status_ctrl: counts out of range");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Selects and loop signals come from other clock domains.
	logic [7:0] syncA_q;
	logic [7:0] syncB_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_q <= `CGS_RST_SYNC;
			syncB_q <= `CGS_RST_SYNC;
		end else begin
			syncA_q <= {loopInTolerance, loopEnabled, lowPowerBypass, referenceSelect,
				loopSelect, stopEntry, clockSourceSelect};
			syncB_q <= syncA_q;
		end
	end
	logic tolS, enS, lpS, refS, loopS, stopS;
	cgs_mode_e modeS;
	assign {tolS, enS, lpS, refS, loopS, stopS} = syncB_q[7:2];
	assign modeS = cgs_mode_e'(syncB_q[1:0]);

	logic chgA_q, chgB_q, chgC_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chgA_q <= 1'b0;
			chgB_q <= 1'b0;
			chgC_q <= 1'b0;
		end else begin
			chgA_q <= settingChange;
			chgB_q <= chgA_q;
			chgC_q <= chgB_q;
		end
	end
	logic stopLast_q, lpLast_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stopLast_q <= 1'b0;
			lpLast_q <= 1'b0;
		end else begin
			stopLast_q <= stopS;
			lpLast_q <= lpS;
		end
	end
	logic disturb;
	logic loopLast_q, refLast_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loopLast_q <= 1'b0;
			refLast_q <= `CGS_RST_REF;
		end else begin
			loopLast_q <= loopS;
			refLast_q <= refS;
		end
	end
	assign disturb = (chgB_q != chgC_q) || (loopS != loopLast_q) || (refS != refLast_q)
		|| (stopS && !stopLast_q) || lpS;

	// ----------------------------------------
	// Status mirrors
	// ----------------------------------------
	logic loopStat_q, refStat_q;
	cgs_mode_e modeStat_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loopStat_q <= 1'b0;
			refStat_q <= `CGS_RST_REF;
			modeStat_q <= cgs_mode_e'(`CGS_RST_MODE);
		end else begin
			loopStat_q <= loopS;
			refStat_q <= refS;
			modeStat_q <= modeS;
		end
	end

	// ----------------------------------------
	// Lock detection
	// ----------------------------------------
	// Lock is claimed only after the loop stays in tolerance for a settling time.
	cgs_lock_e lk_q;
	logic [15:0] lkCnt_q;
	logic lockLost;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lk_q <= CGS_LK_OFF;
			lkCnt_q <= 16'h0000;
		end else begin
			unique case (lk_q)
				CGS_LK_OFF: begin
					lkCnt_q <= 16'h0000;
					if (enS && !lpS) begin
						lk_q <= CGS_LK_ACQ;
					end
				end
				CGS_LK_ACQ: begin
					if (!enS || disturb || !tolS) begin
						lk_q <= enS ? CGS_LK_ACQ : CGS_LK_OFF;
						lkCnt_q <= 16'h0000;
					end else if (lkCnt_q == 16'(LOCK_CYC - 1)) begin
						lk_q <= CGS_LK_LOCKED;
					end else begin
						lkCnt_q <= lkCnt_q + 16'h0001;
					end
				end
				CGS_LK_LOCKED: begin
					lkCnt_q <= 16'h0000;
					if (!enS) begin
						lk_q <= CGS_LK_OFF;
					end else if (disturb || !tolS) begin
						lk_q <= CGS_LK_ACQ;
					end
				end
				default: begin
					lk_q <= CGS_LK_OFF;
				end
			endcase
		end
	end
	assign lockLost = (lk_q == CGS_LK_LOCKED) && enS && !disturb && !tolS;

	// ----------------------------------------
	// Oscillator initialisation
	// ----------------------------------------
	logic ctrlIrqEn_q, oscReq_q, extEn_q;
	logic oscReady_q;
	logic [15:0] oscCnt_q;
	logic extInUse;
	assign extInUse = extEn_q || !refS;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			oscReady_q <= 1'b0;
			oscCnt_q <= 16'h0000;
		end else if (!oscReq_q || (refS && !extEn_q)) begin
			oscReady_q <= 1'b0;
			oscCnt_q <= 16'h0000;
		end else if (extInUse && !oscReady_q) begin
			if (oscCnt_q == 16'(OSC_INIT_CYC - 1)) begin
				oscReady_q <= 1'b1;
			end else begin
				oscCnt_q <= oscCnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Writable bits and interrupt
	// ----------------------------------------
	logic lossFlag_q, trim_q;
	logic [7:0] irqStat_q, irqMask_q;
	logic wrStatus, wrCtrl, wrIrqStat, wrIrqMask;
	assign wrStatus = regWr && regAddr == `CGS_ADDR_STATUS;
	assign wrCtrl = regWr && regAddr == `CGS_ADDR_CTRL;
	assign wrIrqStat = regWr && regAddr == `CGS_ADDR_IRQ_STAT;
	assign wrIrqMask = regWr && regAddr == `CGS_ADDR_IRQ_MASK;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lossFlag_q <= 1'b0;
			trim_q <= 1'b0;
		end else begin
			if (lockLost) begin
				lossFlag_q <= 1'b1;
			end else if (wrStatus && regWdata[`CGS_BIT_LOSS]) begin
				lossFlag_q <= 1'b0;
			end
			if (wrStatus) begin
				trim_q <= regWdata[`CGS_BIT_TRIM];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlIrqEn_q <= 1'b0;
			oscReq_q <= 1'b0;
			extEn_q <= 1'b0;
		end else if (wrCtrl) begin
			ctrlIrqEn_q <= regWdata[`CGS_CTRL_IRQ_EN];
			oscReq_q <= regWdata[`CGS_CTRL_OSC_REQ];
			extEn_q <= regWdata[`CGS_CTRL_EXT_EN];
		end
	end

	// The pending bit mirrors the loss flag event; set wins over a clearing write.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStat_q <= `CGS_RST_BYTE;
			irqMask_q <= `CGS_RST_BYTE;
		end else begin
			irqStat_q[`CGS_BIT_LOSS] <= lockLost
				|| (irqStat_q[`CGS_BIT_LOSS] && !(wrIrqStat && regWdata[`CGS_BIT_LOSS]));
			if (wrIrqMask) begin
				irqMask_q <= regWdata & `CGS_IRQ_MASK_BITS;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
			finePeriodAdjust <= 1'b0;
			oscillatorRequest <= 1'b0;
			externalReferenceEnable <= 1'b0;
			oscCrystalSelect <= 1'b0;
		end else begin
			irq <= (lossFlag_q && ctrlIrqEn_q) || |(irqStat_q & irqMask_q);
			finePeriodAdjust <= trim_q;
			oscillatorRequest <= oscReq_q;
			externalReferenceEnable <= extEn_q;
			oscCrystalSelect <= oscReq_q;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= `CGS_RST_BYTE;
		end else if (regRd) begin
			unique case (regAddr)
				`CGS_ADDR_STATUS: regRdata <= {lossFlag_q, lk_q == CGS_LK_LOCKED, loopStat_q,
					refStat_q, modeStat_q, oscReady_q, trim_q};
				`CGS_ADDR_CTRL: regRdata <= {5'h00, extEn_q, oscReq_q, ctrlIrqEn_q};
				`CGS_ADDR_IRQ_STAT: regRdata <= irqStat_q;
				`CGS_ADDR_IRQ_MASK: regRdata <= irqMask_q;
				default: regRdata <= `CGS_RST_BYTE;
			endcase
		end else begin
			regRdata <= `CGS_RST_BYTE;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_clear_loss;
		@(posedge sys_clk) disable iff (!arst_n)
		(wrStatus && regWdata[`CGS_BIT_LOSS] && !lockLost) |=> !lossFlag_q;
	endproperty
	a_clear_loss: assert property (p_clear_loss) else $error("loss flag not cleared");
	property p_set_loss;
		@(posedge sys_clk) disable iff (!arst_n) lockLost |=> lossFlag_q;
	endproperty
	a_set_loss: assert property (p_set_loss) else $error("loss flag not set");
	property p_irq;
		@(posedge sys_clk) disable iff (!arst_n) irq |-> $past(lossFlag_q) || $past(|irqStat_q);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without flag");
	property p_off;
		@(posedge sys_clk) disable iff (!arst_n) !enS |=> lk_q != CGS_LK_LOCKED;
	endproperty
	a_off: assert property (p_off) else $error("lock while loops off");
	property p_dist;
		@(posedge sys_clk) disable iff (!arst_n) disturb |=> lk_q != CGS_LK_LOCKED;
	endproperty
	a_dist: assert property (p_dist) else $error("lock kept after disturbance");
	property p_loop;
		@(posedge sys_clk) disable iff (!arst_n) ##1 loopStat_q == $past(syncB_q[3]);
	endproperty
	a_loop: assert property (p_loop) else $error("loop status wrong");
	property p_osc;
		@(posedge sys_clk) disable iff (!arst_n) !oscReq_q |=> !oscReady_q;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator ready held");
	property p_trim;
		@(posedge sys_clk) disable iff (!arst_n)
		wrStatus |=> trim_q == $past(regWdata[`CGS_BIT_TRIM]);
	endproperty
	a_trim: assert property (p_trim) else $error("trim not written");
endmodule
